// >>> src/csm_clock_monitor.sv
`timescale 1ns/10ps

module csm_clock_monitor
	import csm_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	input  wire logic                  clk_en,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [APB_AW-1:0]     paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire csm_pkg::csm_osc_s     osc_pins,
	input  wire logic                  power_up_timer_done,
	input  wire logic                  cpu_sleep,
	output csm_pkg::csm_src_e          sysclk_source,
	output logic                       sysclk_hold_low,
	output logic                       exec_stall,
	output logic      [3:0]            internal_freq_select,
	output logic                       tmr1_osc_run,
	output logic                       startup_timeout_flag,
	output logic                       osc_fail_irq
);
	import csm_pkg::*;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_HALT,
		ST_INTERNAL,
		ST_COUNT,
		ST_WAIT_INT_FALL,
		ST_WAIT_EXT_FALL,
		ST_EXTERNAL,
		ST_FAILSAFE
	} csm_state_e;

	csm_state_e  state_reg;              // Sequencer state
	csm_state_e  state_next;             // Its next value
	logic [3:0]  sync1_reg;              // First synchroniser stage
	logic [3:0]  sync2_reg;              // Second stage
	logic [3:0]  sync3_reg;              // Third stage
	logic [3:0]  filt_reg;               // Agreed oscillator levels
	logic [3:0]  filt_d_reg;             // Levels one cycle earlier
	logic [3:0]  agree;                  // Stages two and three agree
	csm_osc_s    fall;                   // Falling edge per oscillator
	csm_osc_s    rise;                   // Rising edge per oscillator
	logic [3:0]  ircf_reg;               // Internal frequency select
	logic [1:0]  scs_reg;                // System clock select
	logic        osf_flag_reg;           // Oscillator fail flag
	logic        osf_flag_next;          // Its next value
	logic        osf_en_reg;             // Fail interrupt enable
	logic        t1en_reg;               // Secondary oscillator enable
	csm_cfg_s    cfg_reg;                // Configuration word
	logic        startup_timeout_flag_reg;               // Start-up timeout flag
	logic        startup_timeout_flag_next;              // Its next value
	logic [10:0] ost_cnt_reg;            // Start-up timer count
	logic [10:0] t1_cnt_reg;             // Secondary warm-up count
	logic        t1_rdy_reg;             // Secondary warm-up done
	logic [4:0]  div_cnt_reg;            // Sample clock divider
	logic        sample_reg;             // Sample clock level
	logic        latch_reg;              // Fail detector latch
	logic        armed_reg;              // A sample rise seen while active
	logic        started_reg;            // Power-up start issued
	logic        sleep_d_reg;            // Sleep level one cycle earlier
	logic        restart_reg;            // Select change written last cycle
	logic [31:0] prdata_reg;             // Read data held for access
	logic [31:0] rd_mux;                 // Read data selected by address
	logic        set_startup_timeout_flag;               // Flag set this cycle
	logic        clr_startup_timeout_flag;               // Flag clear this cycle
	logic        fail_evt;               // Failover this cycle

	// Bus decode
	wire setup      = psel & ~penable;
	wire access     = psel & penable;
	wire hit_ctrl   = (paddr == OFS_OSC_CTRL);
	wire hit_stat   = (paddr == OFS_OSC_STAT);
	wire hit_flags  = (paddr == OFS_IRQ_FLAGS);
	wire hit_ens    = (paddr == OFS_IRQ_ENS);
	wire hit_t1c    = (paddr == OFS_TMR1_CTRL);
	wire hit_cfg    = (paddr == OFS_CONFIG);
	wire hit_any    = hit_ctrl | hit_stat | hit_flags | hit_ens |
		hit_t1c | hit_cfg;
	wire wr_en      = access & pwrite & clk_en;
	wire wr_ctrl    = wr_en & hit_ctrl;
	wire [1:0] scs_wdata = pwdata[CTRL_SCS_LSB +: 2];

	// Source decode from the select field and mode
	wire sel_internal = scs_reg[1] |
		((scs_reg == SCS_PRIMARY) & (cfg_reg.fosc == FOSC_INTERNAL_OSC_BLOCK));
	wire sel_secondary = (scs_reg == SCS_SECONDARY);
	wire needs_ost = sel_secondary |
		((scs_reg == SCS_PRIMARY) & csm_is_crystal(cfg_reg.fosc));
	wire two_speed_ok = cfg_reg.two_speed_enable & (scs_reg == SCS_PRIMARY) &
		csm_is_crystal(cfg_reg.fosc);
	wire mon_fall = sel_secondary ? fall.t1_clk : fall.ext_clk;

	// Start events: power-up, wake from sleep, select change
	wire wake    = sleep_d_reg & ~cpu_sleep;
	wire restart = (~started_reg & power_up_timer_done) | wake |
		restart_reg;

	// Sample clock edges and fail detection
	wire div_wrap    = rise.lf_clk &
		(div_cnt_reg == 5'(CLOCK_FAIL_MONITOR_HALF - 1));
	wire sample_rise = div_wrap & ~sample_reg;
	wire sample_fall = div_wrap & sample_reg;
	wire mon_active  = cfg_reg.fail_monitor_enable & (state_reg == ST_EXTERNAL);
	// A fall in the sample-fall cycle still counts as a live clock
	wire clock_fail_monitor_fail   = mon_active & armed_reg & sample_fall &
		~latch_reg & ~mon_fall;
	wire ost_done    = mon_fall &
		(ost_cnt_reg == 11'(OST_CYCLES - 1));

	// Combine agreeing synchroniser stages into edges
	assign agree = ~(sync2_reg ^ sync3_reg);
	assign fall  = csm_osc_s'(filt_d_reg & ~filt_reg);
	assign rise  = csm_osc_s'(~filt_d_reg & filt_reg);

	// Synchronise oscillator pins; stage one feeds stage two only
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1_reg  <= 4'h0;
			sync2_reg  <= 4'h0;
			sync3_reg  <= 4'h0;
			filt_reg   <= 4'h0;
			filt_d_reg <= 4'h0;
		end
		else if (clk_en)
		begin
			sync1_reg  <= osc_pins;
			sync2_reg  <= sync1_reg;
			sync3_reg  <= sync2_reg;
			filt_reg   <= (agree & sync2_reg) | (~agree & filt_reg);
			filt_d_reg <= filt_reg;
		end
	end

	// Clock sequencer
	always_comb
	begin
		state_next = state_reg;
		set_startup_timeout_flag   = 1'b0;
		clr_startup_timeout_flag   = 1'b0;
		fail_evt   = 1'b0;
		if (cpu_sleep)
		begin
			// Sleep abandons any start-up and any failsafe state
			state_next = ST_HALT;
			clr_startup_timeout_flag   = 1'b1;
		end
		else if (restart)
		begin
			clr_startup_timeout_flag = 1'b1;
			if (sel_internal)
				state_next = ST_INTERNAL;
			else if (needs_ost)
				state_next = ST_COUNT;
			else
			begin
				// Clock and RC sources need no stabilisation
				state_next = ST_EXTERNAL;
				set_startup_timeout_flag   = 1'b1;
			end
		end
		else
		begin
			unique case (state_reg)
				ST_HALT, ST_INTERNAL, ST_FAILSAFE:
				begin
					// Stay on internal clock until a new start
					state_next = state_reg;
				end
				ST_COUNT:
				begin
					if (ost_done)
						state_next = ST_WAIT_INT_FALL;
				end
				ST_WAIT_INT_FALL:
				begin
					if (fall.int_clk)
					begin
						state_next = ST_WAIT_EXT_FALL;
						set_startup_timeout_flag   = ~sel_secondary;
					end
				end
				ST_WAIT_EXT_FALL:
				begin
					if (mon_fall)
						state_next = ST_EXTERNAL;
				end
				ST_EXTERNAL:
				begin
					if (clock_fail_monitor_fail)
					begin
						state_next = ST_FAILSAFE;
						clr_startup_timeout_flag   = 1'b1;
						fail_evt   = 1'b1;
					end
				end
			endcase
		end
	end

	// Flag and fail flag next values; hardware set wins
	assign startup_timeout_flag_next = set_startup_timeout_flag | (startup_timeout_flag_reg & ~clr_startup_timeout_flag);
	assign osf_flag_next = fail_evt |
		((wr_en & hit_flags) ? pwdata[IRQ_OSF_BIT] : osf_flag_reg);

	// Sequencer state, start-up counter and start bookkeeping
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg   <= ST_HALT;
			ost_cnt_reg <= 11'h000;
			startup_timeout_flag_reg    <= 1'b0;
			started_reg <= 1'b0;
			sleep_d_reg <= 1'b0;
			restart_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			state_reg   <= state_next;
			startup_timeout_flag_reg    <= startup_timeout_flag_next;
			started_reg <= started_reg | power_up_timer_done;
			sleep_d_reg <= cpu_sleep;
			restart_reg <= wr_ctrl & (scs_wdata != scs_reg);
			// Any new start, even while counting, begins from zero
			if (state_next != ST_COUNT || state_reg != ST_COUNT ||
				restart)
				ost_cnt_reg <= 11'h000;
			else if (mon_fall)
				ost_cnt_reg <= ost_cnt_reg + 11'h001;
		end
	end

	// Sample clock divider and fail detector latch
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			div_cnt_reg <= 5'h00;
			sample_reg  <= 1'b0;
			latch_reg   <= 1'b0;
			armed_reg   <= 1'b0;
		end
		else if (clk_en)
		begin
			if (div_wrap)
			begin
				div_cnt_reg <= 5'h00;
				sample_reg  <= ~sample_reg;
			end
			else if (rise.lf_clk)
				div_cnt_reg <= div_cnt_reg + 5'h01;
			// External fall sets, sample rise clears; set wins
			if (mon_fall)
				latch_reg <= 1'b1;
			else if (sample_rise)
				latch_reg <= 1'b0;
			if (!mon_active)
				armed_reg <= 1'b0;
			else if (sample_rise)
				armed_reg <= 1'b1;
		end
	end

	// Secondary oscillator warm-up tracking
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			t1_cnt_reg <= 11'h000;
			t1_rdy_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!t1en_reg)
			begin
				t1_cnt_reg <= 11'h000;
				t1_rdy_reg <= 1'b0;
			end
			else if (fall.t1_clk && !t1_rdy_reg)
			begin
				t1_cnt_reg <= t1_cnt_reg + 11'h001;
				t1_rdy_reg <= (t1_cnt_reg == 11'(OST_CYCLES - 1));
			end
		end
	end

	// Software registers; hardware never writes the select field
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			ircf_reg     <= IRCF_RESET;
			scs_reg      <= SCS_RESET;
			osf_flag_reg <= 1'b0;
			osf_en_reg   <= 1'b0;
			t1en_reg     <= 1'b0;
			cfg_reg      <= '{FAIL_MONITOR_ENABLE_RESET, TWO_SPEED_ENABLE_RESET, FOSC_RESET};
			prdata_reg   <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			osf_flag_reg <= osf_flag_next;
			if (wr_ctrl)
			begin
				ircf_reg <= pwdata[CTRL_IRCF_LSB +: 4];
				scs_reg  <= scs_wdata;
			end
			if (wr_en && hit_ens)
				osf_en_reg <= pwdata[IRQ_OSF_BIT];
			if (wr_en && hit_t1c)
				t1en_reg <= pwdata[T1C_OSCEN_BIT];
			if (wr_en && hit_cfg)
			begin
				cfg_reg.fosc  <= pwdata[CFG_FOSC_LSB +: 3];
				cfg_reg.two_speed_enable  <= pwdata[CFG_TWO_SPEED_ENABLE_BIT];
				cfg_reg.fail_monitor_enable <= pwdata[CFG_FAIL_MONITOR_ENABLE_BIT];
			end
			if (setup)
				prdata_reg <= rd_mux;
		end
	end

	// Read data selection
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl)
		begin
			rd_mux[CTRL_IRCF_LSB +: 4] = ircf_reg;
			rd_mux[CTRL_SCS_LSB +: 2]  = scs_reg;
		end
		if (hit_stat)
		begin
			// Secondary reads ready whenever it is disabled
			rd_mux[STAT_T1RDY_BIT] = ~t1en_reg | t1_rdy_reg;
			rd_mux[STAT_STARTUP_TIMEOUT_FLAG_BIT]  = startup_timeout_flag_reg;
		end
		if (hit_flags)
			rd_mux[IRQ_OSF_BIT] = osf_flag_reg;
		if (hit_ens)
			rd_mux[IRQ_OSF_BIT] = osf_en_reg;
		if (hit_t1c)
			rd_mux[T1C_OSCEN_BIT] = t1en_reg;
		if (hit_cfg)
		begin
			rd_mux[CFG_FOSC_LSB +: 3] = cfg_reg.fosc;
			rd_mux[CFG_TWO_SPEED_ENABLE_BIT]      = cfg_reg.two_speed_enable;
			rd_mux[CFG_FAIL_MONITOR_ENABLE_BIT]     = cfg_reg.fail_monitor_enable;
		end
	end

	// Outputs
	assign prdata  = prdata_reg;
	assign pready  = 1'b1;
	assign pslverr = access & ~hit_any;
	assign sysclk_source = (state_reg != ST_EXTERNAL) ? SRC_INTERNAL :
		(sel_secondary ? SRC_SECONDARY : SRC_PRIMARY);
	assign sysclk_hold_low      = (state_reg == ST_WAIT_EXT_FALL);
	assign exec_stall = ((state_reg == ST_COUNT) ||
		(state_reg == ST_WAIT_INT_FALL)) &
		(scs_reg == SCS_PRIMARY) & ~two_speed_ok;
	assign internal_freq_select = ircf_reg;
	assign tmr1_osc_run         = t1en_reg;
	assign startup_timeout_flag = startup_timeout_flag_reg;
	assign osc_fail_irq         = osf_flag_reg & osf_en_reg;

	// Checks
	a_sleep_abort: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		clk_en && cpu_sleep |=> !startup_timeout_flag &&
			sysclk_source == SRC_INTERNAL)
		else $error("sleep did not abort start-up");

	a_startup_timeout_flag_set_edge: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		clk_en && !cpu_sleep && !restart &&
		state_reg == ST_WAIT_INT_FALL && fall.int_clk &&
		scs_reg == SCS_PRIMARY
		|=> startup_timeout_flag && sysclk_hold_low)
		else $error("flag not set at internal fall");

	a_ost_full_count: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		$rose(state_reg == ST_WAIT_INT_FALL)
		|-> $past(ost_cnt_reg) == 11'd1023)
		else $error("start-up timer ended early");

	a_fail_switch: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		clk_en && clock_fail_monitor_fail && !cpu_sleep && !restart
		|=> sysclk_source == SRC_INTERNAL && osf_flag_reg)
		else $error("failover did not happen");

	a_fail_irq: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		clk_en && fail_evt && osf_en_reg && !wr_en |=> osc_fail_irq)
		else $error("fail interrupt missing");

	a_no_two_speed: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		state_reg == ST_COUNT && scs_reg == SCS_PRIMARY
		|-> csm_is_crystal(cfg_reg.fosc))
		else $error("start-up count outside crystal mode");

	a_monitor_idle: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		$rose(state_reg == ST_FAILSAFE)
		|-> $past(state_reg) == ST_EXTERNAL && $past(cfg_reg.fail_monitor_enable))
		else $error("monitor active before expiry");

	a_sample_div: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		$changed(sample_reg) |-> $past(div_cnt_reg) == 5'd31)
		else $error("sample clock divide wrong");

	a_scs_kept: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		!$past(wr_ctrl) |-> $stable(scs_reg))
		else $error("select changed without a write");

endmodule : csm_clock_monitor

// >>> src/csm_pkg.sv
package csm_pkg;

	// Register byte offsets on the APB
	localparam int          APB_AW        = 8;
	localparam logic [7:0]  OFS_OSC_CTRL  = 8'h00;
	localparam logic [7:0]  OFS_OSC_STAT  = 8'h04;
	localparam logic [7:0]  OFS_IRQ_FLAGS = 8'h08;
	localparam logic [7:0]  OFS_IRQ_ENS   = 8'h0C;
	localparam logic [7:0]  OFS_TMR1_CTRL = 8'h10;
	localparam logic [7:0]  OFS_CONFIG    = 8'h14;

	// Field positions
	localparam int CTRL_SCS_LSB   = 0;
	localparam int CTRL_IRCF_LSB  = 3;
	localparam int STAT_STARTUP_TIMEOUT_FLAG_BIT  = 5;
	localparam int STAT_T1RDY_BIT = 7;
	localparam int IRQ_OSF_BIT    = 7;
	localparam int T1C_OSCEN_BIT  = 3;
	localparam int CFG_FOSC_LSB   = 0;
	localparam int CFG_TWO_SPEED_ENABLE_BIT   = 12;
	localparam int CFG_FAIL_MONITOR_ENABLE_BIT  = 13;

	// Reset values
	localparam logic [3:0] IRCF_RESET  = 4'h7;
	localparam logic [1:0] SCS_RESET   = 2'h0;
	localparam logic [2:0] FOSC_RESET  = 3'h0;
	localparam logic       TWO_SPEED_ENABLE_RESET  = 1'b1;
	localparam logic       FAIL_MONITOR_ENABLE_RESET = 1'b1;

	// Primary oscillator modes; codes 5 to 7 are external clock input
	localparam logic [2:0] FOSC_LP     = 3'h0;
	localparam logic [2:0] FOSC_XT     = 3'h1;
	localparam logic [2:0] FOSC_HS     = 3'h2;
	localparam logic [2:0] FOSC_RC     = 3'h3;
	localparam logic [2:0] FOSC_INTERNAL_OSC_BLOCK = 3'h4;

	// Clock select codes; upper bit set means internal block
	localparam logic [1:0] SCS_PRIMARY   = 2'h0;
	localparam logic [1:0] SCS_SECONDARY = 2'h1;

	// Timing counts in oscillator cycles
	localparam int OST_CYCLES = 1024;
	localparam int CLOCK_FAIL_MONITOR_DIV   = 64;
	localparam int CLOCK_FAIL_MONITOR_HALF  = CLOCK_FAIL_MONITOR_DIV / 2;

	// Raw oscillator inputs
	typedef struct packed {
		logic ext_clk;
		logic t1_clk;
		logic lf_clk;
		logic int_clk;
	} csm_osc_s;

	// Configuration word fields
	typedef struct packed {
		logic       fail_monitor_enable;
		logic       two_speed_enable;
		logic [2:0] fosc;
	} csm_cfg_s;

	// System clock source currently in use
	typedef enum logic [1:0] {
		SRC_INTERNAL,
		SRC_PRIMARY,
		SRC_SECONDARY
	} csm_src_e;

	// True for the three crystal modes
	function automatic logic csm_is_crystal(input logic [2:0] fosc);
		csm_is_crystal = (fosc == FOSC_LP) || (fosc == FOSC_XT) ||
			(fosc == FOSC_HS);
	endfunction : csm_is_crystal

endpackage : csm_pkg

// >>> testbench/csm_clock_monitor_tb.sv
`timescale 1ns/10ps

module csm_clock_monitor_tb;
	import csm_pkg::*;

	logic        clk_sys, resetn, clk_en;    // Clock, reset, enable
	logic        psel, penable, pwrite;      // Bus control
	logic [7:0]  paddr;                      // Bus address
	logic [31:0] pwdata, prdata, rdat;       // Bus data
	logic        pready, pslverr, err_seen;  // Bus answer
	csm_osc_s    osc_pins;                   // Oscillator levels
	logic        ext_run, pwr_done, cpu_sleep;
	csm_src_e    sysclk_source;              // Source in use
	logic        hold_low, exec_stall, tmr1_osc_run, flag, irq;
	logic [3:0]  freq;                       // Internal frequency code
	logic        seen_hold;                  // Hold phase observed
	int          n_mismatch, n_checks, cycles;

	csm_osc_model i_osc (.clk_sys(clk_sys), .ext_run(ext_run),
		.osc_pins(osc_pins));

	csm_clock_monitor i_dut (.clk_sys(clk_sys), .resetn(resetn),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_pins(osc_pins),
		.power_up_timer_done(pwr_done), .cpu_sleep(cpu_sleep),
		.sysclk_source(sysclk_source), .sysclk_hold_low(hold_low),
		.exec_stall(exec_stall), .internal_freq_select(freq),
		.tmr1_osc_run(tmr1_osc_run), .startup_timeout_flag(flag),
		.osc_fail_irq(irq));

	// Clock generator
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Hang guard and hold-phase watcher
	always @(posedge clk_sys)
	begin
		cycles++;
		if (hold_low === 1'b1)
			seen_hold = 1'b1;
		if (cycles == 100000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc

	// One bus transfer: setup, access held until ready
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge clk_sys);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdat     = prdata;
		err_seen = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat & m, e);
	endtask : rdc

	task automatic src(input csm_src_e s);
		chk(32'(sysclk_source), 32'(s));
	endtask : src

	task automatic wait_src(input csm_src_e s, input int lim);
		for (int i = 0; i < lim && sysclk_source !== s; i++)
			@(posedge clk_sys);
	endtask : wait_src

	// Sleep briefly, then wake to start a new sequence
	task automatic nap();
		cpu_sleep <= 1'b1;
		cyc(10);
		cpu_sleep <= 1'b0;
	endtask : nap

	task automatic t_reset();
		src(SRC_INTERNAL);
		chk(32'(freq), 32'h7);
		rdc(OFS_OSC_CTRL, 32'h7B, 32'h38);
		rdc(OFS_CONFIG, 32'h3007, 32'h3000);
		rdc(OFS_OSC_STAT, 32'hA0, 32'h80);
		rdc(8'h40, 32'hFFFFFFFF, 32'h0);
		chk(32'(err_seen), 32'h1);
		clk_en <= 1'b0;
		apb(1'b1, OFS_OSC_CTRL, 32'h50);
		clk_en <= 1'b1;
		rdc(OFS_OSC_CTRL, 32'h7B, 32'h38);
		cyc(200);
		src(SRC_INTERNAL);
	endtask : t_reset

	task automatic t_twospeed();
		seen_hold = 1'b0;
		pwr_done <= 1'b1;
		cyc(20);
		chk(32'(exec_stall), 32'h0);
		cyc(5880);
		src(SRC_INTERNAL);
		chk(32'(flag), 32'h0);
		wait_src(SRC_PRIMARY, 800);
		src(SRC_PRIMARY);
		chk(32'(flag), 32'h1);
		chk(32'(seen_hold), 32'h1);
	endtask : t_twospeed

	task automatic t_fail();
		apb(1'b1, OFS_IRQ_ENS, 32'h80);
		ext_run <= 1'b0;
		cyc(200);
		src(SRC_PRIMARY);
		wait_src(SRC_INTERNAL, 1200);
		src(SRC_INTERNAL);
		chk(32'(irq), 32'h1);
		chk(32'(flag), 32'h0);
		rdc(OFS_IRQ_FLAGS, 32'h80, 32'h80);
		rdc(OFS_OSC_CTRL, 32'h7B, 32'h38);
		ext_run <= 1'b1;
		cyc(300);
		src(SRC_INTERNAL);
		apb(1'b1, OFS_IRQ_ENS, 32'h0);
		cyc(1);
		chk(32'(irq), 32'h0);
		apb(1'b1, OFS_IRQ_FLAGS, 32'h0);
		rdc(OFS_IRQ_FLAGS, 32'h80, 32'h0);
	endtask : t_fail

	task automatic t_recover();
		apb(1'b1, OFS_OSC_CTRL, 32'h3A);
		cyc(10);
		src(SRC_INTERNAL);
		apb(1'b1, OFS_OSC_CTRL, 32'h38);
		cyc(5800);
		src(SRC_INTERNAL);
		wait_src(SRC_PRIMARY, 1200);
		src(SRC_PRIMARY);
		chk(32'(flag), 32'h1);
	endtask : t_recover

	task automatic t_sleep();
		cpu_sleep <= 1'b1;
		cyc(10);
		src(SRC_INTERNAL);
		chk(32'(flag), 32'h0);
		cpu_sleep <= 1'b0;
		cyc(3000);
		nap();
		chk(32'(flag), 32'h0);
		cyc(5800);
		src(SRC_INTERNAL);
		wait_src(SRC_PRIMARY, 1200);
		src(SRC_PRIMARY);
	endtask : t_sleep

	task automatic t_modes();
		logic [2:0] modes [3] = '{3'h3, 3'h5, 3'h7};
		foreach (modes[i])
		begin
			apb(1'b1, OFS_CONFIG, {29'h600, modes[i]});
			nap();
			cyc(20);
			src(SRC_PRIMARY);
			chk(32'(flag), 32'h1);
		end
		ext_run <= 1'b0;
		wait_src(SRC_INTERNAL, 1200);
		src(SRC_INTERNAL);
		ext_run <= 1'b1;
		apb(1'b1, OFS_CONFIG, 32'h1005);
		nap();
		cyc(20);
		ext_run <= 1'b0;
		cyc(1500);
		src(SRC_PRIMARY);
		ext_run <= 1'b1;
		apb(1'b1, OFS_CONFIG, 32'h2001);
		nap();
		cyc(20);
		chk(32'(exec_stall), 32'h1);
		wait_src(SRC_PRIMARY, 7000);
		src(SRC_PRIMARY);
		chk(32'(exec_stall), 32'h0);
		apb(1'b1, OFS_CONFIG, 32'h3004);
		nap();
		cyc(20);
		src(SRC_INTERNAL);
		chk(32'(flag), 32'h0);
	endtask : t_modes

	task automatic t_secondary();
		apb(1'b1, OFS_TMR1_CTRL, 32'h08);
		cyc(1);
		chk(32'(tmr1_osc_run), 32'h1);
		rdc(OFS_OSC_STAT, 32'h80, 32'h0);
		for (int i = 0; i < 300; i++)
		begin
			apb(1'b0, OFS_OSC_STAT, 32'h0);
			if (rdat[7] === 1'b1)
				break;
			cyc(50);
		end
		chk(rdat & 32'h80, 32'h80);
		apb(1'b1, OFS_OSC_CTRL, 32'h39);
		wait_src(SRC_SECONDARY, 9500);
		src(SRC_SECONDARY);
		chk(32'(flag), 32'h0);
		apb(1'b1, OFS_TMR1_CTRL, 32'h0);
		cyc(1);
		chk(32'(tmr1_osc_run), 32'h0);
	endtask : t_secondary

	// Reset, then the scenarios in order
	initial
	begin
		{resetn, psel, penable, pwrite, pwr_done, cpu_sleep} = '0;
		{n_mismatch, n_checks, cycles} = '0;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		clk_en    = 1'b1;
		ext_run   = 1'b1;
		seen_hold = 1'b0;
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_twospeed();
		t_fail();
		t_recover();
		t_sleep();
		t_modes();
		t_secondary();
		print_verdict();
	end

endmodule : csm_clock_monitor_tb

// >>> testbench/csm_osc_model.sv
`timescale 1ns/10ps

// Oscillator sources that feed the clock monitor pins
module csm_osc_model
	import csm_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire logic          ext_run,
	output csm_pkg::csm_osc_s  osc_pins
);
	logic [1:0] ext_cnt  = 2'h0;  // Divides the crystal rate by six
	logic [2:0] slow_cnt = 3'h0;  // Divides the slow sources by eight
	logic       ext_lvl  = 1'b0;  // Crystal level, frozen while stopped

	// A dead crystal holds its last level, which is what the monitor sees
	always_ff @(posedge clk_sys)
	begin
		slow_cnt <= slow_cnt + 3'h1;
		if (ext_run)
		begin
			ext_cnt <= (ext_cnt == 2'h2) ? 2'h0 : ext_cnt + 2'h1;
			if (ext_cnt == 2'h2)
				ext_lvl <= ~ext_lvl;
		end
	end

	// Slow sources share one divider; timekeeping crystal runs inverted
	assign osc_pins = {ext_lvl, ~slow_cnt[2], slow_cnt[2], slow_cnt[2]};

endmodule : csm_osc_model
